// *** hdl/hlsow_deglitch.sv ***
`timescale 1ns/1ns
module hlsow_deglitch #(
    parameter int SHORT_CYC = hlsow_pkg::DEGLITCH_SHORT_CYC,
    parameter int LONG_CYC = hlsow_pkg::DEGLITCH_LONG_CYC
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic restart_in,
    input wire logic level_in,
    input wire logic long_in,
    output logic done_out
);
    logic [hlsow_pkg::CNT_W-1:0] cnt_r;
    logic [hlsow_pkg::CNT_W-1:0] limit;

    assign limit = long_in ? hlsow_pkg::CNT_W'(LONG_CYC - 1)
                           : hlsow_pkg::CNT_W'(SHORT_CYC - 1);

    // Done pulses for one cycle each time the level has lasted the full time, then the count restarts
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt_r <= '0;
            done_out <= 1'b0;
        end else if (restart_in || !level_in) begin
            cnt_r <= '0;
            done_out <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r <= '0;
            done_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            done_out <= 1'b0;
        end
    end
endmodule

// *** hdl/hlsow_top.sv ***
`timescale 1ns/1ns
module hlsow_top #(
    parameter int SHORT_CYC = hlsow_pkg::DEGLITCH_SHORT_CYC,
    parameter int LONG_CYC = hlsow_pkg::DEGLITCH_LONG_CYC
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Test register writes, external links only
    input wire logic test_wr_in,
    input wire logic [1:0] link_select_field_in,
    input wire logic wake_filter_time_select_in,
    input wire logic pin_transceiver_enable_in,
    input wire logic owner_link_in,
    input wire logic proc_reset_in,
    input wire logic test_mbox_wr_in,
    input wire logic [7:0] test_mbox_data_in,
    // Processor extended SFR writes
    input wire logic sfr_wr_in,
    input wire logic sfr_dac_on_in,
    input wire logic sfr_transceiver_switch_on_in,
    input wire logic sfr_mbox_wr_in,
    input wire logic [7:0] sfr_mbox_data_in,
    input wire logic irq_ack_in,
    // Analog comparator and link side
    input wire logic wake_overvoltage_level_in,
    input wire logic pin_normal_level_in,
    input wire logic link_rx_in,
    input wire logic link_tx_req_in,
    input wire logic link_tx_bit_in,
    // Memory requests
    input wire logic proc_mem_req_in,
    input wire logic link_mem_req_in,
    output logic proc_mem_grant_out,
    output logic link_mem_grant_out,
    output logic proc_reset_out,
    output logic [1:0] link_select_out,
    output logic spi_en_out,
    output logic i2c_en_out,
    output logic single_pin_link_en_out,
    output logic gpio_i2c_mode_out,
    output logic dac_on_out,
    output logic transceiver_switch_out,
    output logic link_rx_out,
    output logic link_tx_out,
    output logic link_tx_oe_out,
    output logic link_wake_irq_out,
    output logic wake_request_out,
    output logic [7:0] mbox_to_proc_out,
    output logic [7:0] mbox_to_link_out
);
    typedef enum logic [3:0] {
        HLSOW_IDLE = 4'h1,
        HLSOW_HIGH = 4'h2,
        HLSOW_BACK = 4'h4,
        HLSOW_DONE = 4'h8
    } hlsow_wake_e;

    hlsow_wake_e wake_r;
    hlsow_wake_e wake_nxt;
    logic [1:0] sel_r;
    logic filt_r;
    logic transceiver_switch_en_r;
    logic owner_r;
    logic preset_r;
    logic dac_sfr_r;
    logic transceiver_switch_sfr_r;
    logic irq_r;
    logic done;
    logic level;
    logic restart;
    logic wake_ok;

    function automatic logic is_code(input logic [1:0] s, input logic [1:0] c);
        is_code = (s == c);
    endfunction

    // Control written only over test space, so links alone own it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sel_r <= hlsow_pkg::LINK_SEL_RST;
            filt_r <= hlsow_pkg::FILTER_SEL_RST;
            transceiver_switch_en_r <= 1'b0;
            owner_r <= 1'b0;
            preset_r <= 1'b0;
        end else if (test_wr_in) begin
            sel_r <= link_select_field_in;
            filt_r <= wake_filter_time_select_in;
            transceiver_switch_en_r <= pin_transceiver_enable_in;
            owner_r <= owner_link_in;
            preset_r <= proc_reset_in;
        end
    end

    // Processor switches, set by wake service routine
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dac_sfr_r <= 1'b1;
            transceiver_switch_sfr_r <= 1'b0;
        end else if (sfr_wr_in && !preset_r) begin
            dac_sfr_r <= sfr_dac_on_in;
            transceiver_switch_sfr_r <= sfr_transceiver_switch_on_in;
        end
    end

    // Wake only while the DAC drives the pin and no slave link is chosen
    assign wake_ok = dac_sfr_r && !transceiver_switch_sfr_r && !transceiver_switch_en_r
                     && !is_code(sel_r, hlsow_pkg::LINK_SPI)
                     && !is_code(sel_r, hlsow_pkg::LINK_I2C)
                     && !is_code(sel_r, hlsow_pkg::LINK_SPL)
                     && !preset_r;
    assign level = (wake_r == HLSOW_BACK) ? pin_normal_level_in
                                          : wake_overvoltage_level_in;
    assign restart = (wake_r != wake_nxt);

    hlsow_deglitch #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_deglitch (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .restart_in(restart),
        .level_in(level && wake_ok && wake_r != HLSOW_DONE),
        .long_in(filt_r),
        .done_out(done)
    );

    always_comb begin
        wake_nxt = wake_r;
        unique case (wake_r)
            HLSOW_IDLE: begin
                if (wake_ok && wake_overvoltage_level_in) begin
                    wake_nxt = HLSOW_HIGH;
                end
            end
            HLSOW_HIGH: begin
                if (!wake_ok || !wake_overvoltage_level_in) begin
                    wake_nxt = HLSOW_IDLE;
                end else if (done) begin
                    wake_nxt = HLSOW_BACK;
                end
            end
            HLSOW_BACK: begin
                if (!wake_ok || !pin_normal_level_in) begin
                    wake_nxt = HLSOW_IDLE;
                end else if (done) begin
                    wake_nxt = HLSOW_DONE;
                end
            end
            HLSOW_DONE: begin
                if (!wake_ok) begin
                    wake_nxt = HLSOW_IDLE;
                end
            end
            default: wake_nxt = HLSOW_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_r <= HLSOW_IDLE;
        end else begin
            wake_r <= wake_nxt;
        end
    end

    // Set wins over acknowledge so a late wake is not lost
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_r <= 1'b0;
        end else if (wake_r == HLSOW_BACK && wake_nxt == HLSOW_DONE) begin
            irq_r <= 1'b1;
        end else if (irq_ack_in) begin
            irq_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_wake_irq_out <= 1'b0;
            wake_request_out <= 1'b0;
        end else begin
            link_wake_irq_out <= irq_r;
            wake_request_out <= (wake_nxt == HLSOW_BACK)
                                || (wake_nxt == HLSOW_DONE);
        end
    end

    // Mode decode and pin switching
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_select_out <= hlsow_pkg::LINK_SEL_RST;
            spi_en_out <= 1'b0;
            i2c_en_out <= 1'b0;
            single_pin_link_en_out <= 1'b0;
            gpio_i2c_mode_out <= 1'b0;
            dac_on_out <= 1'b1;
            transceiver_switch_out <= 1'b0;
            proc_reset_out <= 1'b0;
        end else begin
            link_select_out <= sel_r;
            spi_en_out <= is_code(sel_r, hlsow_pkg::LINK_SPI);
            i2c_en_out <= is_code(sel_r, hlsow_pkg::LINK_I2C);
            gpio_i2c_mode_out <= is_code(sel_r,
                                         hlsow_pkg::LINK_I2C);
            single_pin_link_en_out <= is_code(sel_r, hlsow_pkg::LINK_SPL)
                                      || transceiver_switch_en_r || transceiver_switch_sfr_r;
            // Off in code 0b10, under overdrive and once back period ends
            dac_on_out <= !is_code(sel_r, hlsow_pkg::LINK_SPL)
                          && dac_sfr_r && !transceiver_switch_en_r && !transceiver_switch_sfr_r
                          && wake_nxt != HLSOW_HIGH
                          && wake_nxt != HLSOW_DONE;
            transceiver_switch_out <= transceiver_switch_en_r || transceiver_switch_sfr_r;
            proc_reset_out <= preset_r;
        end
    end

    // Exclusive memory grant
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            proc_mem_grant_out <= 1'b0;
            link_mem_grant_out <= 1'b0;
        end else begin
            proc_mem_grant_out <= !owner_r && proc_mem_req_in
                                  && !preset_r;
            link_mem_grant_out <= owner_r && link_mem_req_in;
        end
    end

    // Receive data and transmit enable pass only with the transceiver connected; rx idles recessive
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_rx_out <= 1'b1;
            link_tx_out <= 1'b1;
            link_tx_oe_out <= 1'b0;
        end else begin
            link_rx_out <= transceiver_switch_out ? link_rx_in
                                                  : 1'b1;
            link_tx_out <= link_tx_bit_in;
            link_tx_oe_out <= transceiver_switch_out && link_tx_req_in
                              && !link_tx_bit_in;
        end
    end

    // Mailbox, one byte each way
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mbox_to_proc_out <= hlsow_pkg::MBOX_RST;
            mbox_to_link_out <= hlsow_pkg::MBOX_RST;
        end else begin
            if (test_mbox_wr_in) begin
                mbox_to_proc_out <= test_mbox_data_in;
            end
            if (sfr_mbox_wr_in) begin
                mbox_to_link_out <= sfr_mbox_data_in;
            end
        end
    end

    property p_excl;
        @(posedge clk_in) disable iff (!arst_n_in)
        !(proc_mem_grant_out && link_mem_grant_out);
    endproperty
    a_excl: assert property (p_excl) else $error("both granted");

    property p_irq_cause;
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(irq_r) |-> $past(wake_r) == HLSOW_BACK;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without wake");

    property p_irq_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        irq_r && !irq_ack_in |=> irq_r;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped");

    property p_i2c;
        @(posedge clk_in) disable iff (!arst_n_in)
        sel_r == hlsow_pkg::LINK_I2C |=> gpio_i2c_mode_out;
    endproperty
    a_i2c: assert property (p_i2c)
        else $error("i2c pins not set");

    property p_dac_off;
        @(posedge clk_in) disable iff (!arst_n_in)
        transceiver_switch_en_r |=> !dac_on_out && transceiver_switch_out;
    endproperty
    a_dac_off: assert property (p_dac_off) else $error("dac on");

    property p_tx;
        @(posedge clk_in) disable iff (!arst_n_in)
        link_tx_oe_out |-> $past(link_tx_req_in);
    endproperty
    a_tx: assert property (p_tx) else $error("tx unrequested");

    property p_high;
        @(posedge clk_in) disable iff (!arst_n_in)
        $rose(wake_request_out) |-> $past(done);
    endproperty
    a_high: assert property (p_high) else $error("early wake");

    property p_mode;
        @(posedge clk_in) disable iff (!arst_n_in)
        wake_r != HLSOW_IDLE |-> $past(wake_ok);
    endproperty
    a_mode: assert property (p_mode)
        else $error("wake in link mode");

    c_wake: cover property (@(posedge clk_in) $rose(link_wake_irq_out));
    c_i2c: cover property (@(posedge clk_in) $rose(gpio_i2c_mode_out));
    c_link: cover property (@(posedge clk_in) link_mem_grant_out);
endmodule

// *** shared/hlsow_pkg.sv ***
package hlsow_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int DEGLITCH_SHORT_MS = 1;
    localparam int DEGLITCH_LONG_MS = 10;
    localparam int DEGLITCH_SHORT_CYC = CLK_HZ / 1000 * DEGLITCH_SHORT_MS;
    localparam int DEGLITCH_LONG_CYC = CLK_HZ / 1000 * DEGLITCH_LONG_MS;
    localparam int CNT_W = 20;
    localparam logic [1:0] LINK_SPI = 2'h0;
    localparam logic [1:0] LINK_I2C = 2'h1;
    localparam logic [1:0] LINK_SPL = 2'h2;
    localparam logic [1:0] LINK_SEL_RST = 2'h0;
    localparam logic FILTER_SEL_RST = 1'h0;
    localparam int MBOX_W = 8;
    localparam logic [7:0] MBOX_RST = 8'h00;
endpackage

// *** testbench/hlsow_master_model.sv ***
`timescale 1ns/1ns
module hlsow_master_model (
    input wire logic clk_in,
    output logic ov_level_out,
    output logic norm_level_out,
    output logic rx_out
);
    initial begin
        ov_level_out = 1'b0;
        norm_level_out = 1'b0;
        rx_out = 1'b1; // Released line rests recessive
    end
    // Link level from the master once the transceiver is in the path
    task automatic drive(input logic b);
        rx_out = b;
    endtask
    // Overvoltage for hi cycles, then back to 5 V for lo
    task automatic wake(input int hi, input int lo);
        @(posedge clk_in) #1 ov_level_out = 1'b1;
        repeat (hi) @(posedge clk_in);
        #1 ov_level_out = 1'b0;
        norm_level_out = 1'b1;
        repeat (lo) @(posedge clk_in);
        #1 norm_level_out = 1'b0;
    endtask
endmodule

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam int SC = 8;
    localparam int LC = 16;
    // Spare code: no slave link, DAC drives the pin, wake allowed
    localparam logic [1:0] NOSEL = 2'h3;
    logic clk_in = 1'b0;
    logic rst_n, tw, filt, xen, own, prst, mwr, swr, sdac, sxcvr, smwr;
    logic ack, txreq, txbit, preq, lreq;
    logic [1:0] sel;
    logic [7:0] mdat, smdat;
    wire logic ov, norm, rx;
    logic pg, lg, prso, spi, i2c, spl, gpio, dac, xsw, txoe, irq;
    logic rxo, txo, wrq;
    logic [1:0] selo;
    logic [7:0] m2p, m2l;
    int fails = 0;
    int checked = 0;
    int q_id[$];
    logic [7:0] q_exp[$];
    int w_id;
    logic [7:0] w_exp, w_val;
    logic [31:0] seed = 32'h000145A2;
    string nm[17] = '{"sel", "spi", "i2c", "spl", "gpio", "dac", "xsw",
        "irq", "lgrant", "pgrant", "m2p", "m2l", "txoe", "prst", "rx",
        "tx", "wreq"};
    event look;

    always #5 clk_in = ~clk_in;

    hlsow_master_model mst (.clk_in(clk_in), .ov_level_out(ov),
        .norm_level_out(norm), .rx_out(rx));

    hlsow_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) dut (
        .clk_in(clk_in), .arst_n_in(rst_n), .test_wr_in(tw),
        .link_select_field_in(sel), .wake_filter_time_select_in(filt),
        .pin_transceiver_enable_in(xen), .owner_link_in(own),
        .proc_reset_in(prst), .test_mbox_wr_in(mwr),
        .test_mbox_data_in(mdat), .sfr_wr_in(swr), .sfr_dac_on_in(sdac),
        .sfr_transceiver_switch_on_in(sxcvr), .sfr_mbox_wr_in(smwr),
        .sfr_mbox_data_in(smdat), .irq_ack_in(ack),
        .wake_overvoltage_level_in(ov), .pin_normal_level_in(norm),
        .link_rx_in(rx), .link_tx_req_in(txreq), .link_tx_bit_in(txbit),
        .proc_mem_req_in(preq), .link_mem_req_in(lreq),
        .proc_mem_grant_out(pg), .link_mem_grant_out(lg),
        .proc_reset_out(prso), .link_select_out(selo), .spi_en_out(spi),
        .i2c_en_out(i2c), .single_pin_link_en_out(spl),
        .gpio_i2c_mode_out(gpio), .dac_on_out(dac),
        .transceiver_switch_out(xsw), .link_rx_out(rxo), .link_tx_out(txo),
        .link_tx_oe_out(txoe), .link_wake_irq_out(irq),
        .wake_request_out(wrq), .mbox_to_proc_out(m2p),
        .mbox_to_link_out(m2l));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] obs(input int i);
        case (i)
            0: return {6'h00, selo};
            1: return {7'h00, spi};
            2: return {7'h00, i2c};
            3: return {7'h00, spl};
            4: return {7'h00, gpio};
            5: return {7'h00, dac};
            6: return {7'h00, xsw};
            7: return {7'h00, irq};
            8: return {7'h00, lg};
            9: return {7'h00, pg};
            10: return m2p;
            11: return m2l;
            12: return {7'h00, txoe};
            13: return {7'h00, prso};
            14: return {7'h00, rxo};
            15: return {7'h00, txo};
            default: return {7'h00, wrq};
        endcase
    endfunction

    task automatic chk(input int id, input logic [7:0] e);
        q_id.push_back(id);
        q_exp.push_back(e);
        -> look;
    endtask

    always @(look) begin
        while (q_id.size() > 0) begin
            w_id = q_id.pop_front();
            w_exp = q_exp.pop_front();
            w_val = obs(w_id);
            checked++;
            if (w_val !== w_exp) begin
                fails++;
                $display("[ERR] %s expected %0h seen %0h", nm[w_id],
                    w_exp, w_val);
            end
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic twr(input logic [1:0] s, input logic f, x, o, p);
        sel = s;
        filt = f;
        xen = x;
        own = o;
        prst = p;
        tw = 1'b1;
        cyc(1);
        tw = 1'b0;
        cyc(3);
    endtask

    task automatic stop_test;
        #1;
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        {rst_n, tw, sel, filt, xen, own, prst, mwr, swr, sxcvr} = '0;
        {smwr, ack, txreq, txbit, preq, lreq, mdat, smdat} = '0;
        sdac = 1'b1;
        repeat (12) @(posedge clk_in);
        #1 rst_n = 1'b1;
        cyc(1);
        chk(0, 8'h00);
        chk(5, 8'h01);
        for (int k = 0; k < 3; k++) begin
            twr(k[1:0], 1'b0, 1'b0, 1'b0, 1'b0);
            chk(0, 8'(k));
            chk(1, {7'h00, k == 0});
            chk(2, {7'h00, k == 1});
            chk(4, {7'h00, k == 1});
            chk(3, {7'h00, k == 2});
            chk(5, {7'h00, k != 2});
        end
        // Processor parked in reset in the same write that gives links the memory
        twr(hlsow_pkg::LINK_SPI, 1'b0, 1'b0, 1'b1, 1'b1);
        preq = 1'b1;
        lreq = 1'b1;
        cyc(2);
        chk(8, 8'h01);
        chk(9, 8'h00);
        chk(13, 8'h01);
        twr(hlsow_pkg::LINK_SPI, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(8, 8'h00);
        chk(9, 8'h01);
        mdat = 8'(rnd());
        smdat = 8'(rnd());
        mwr = 1'b1;
        smwr = 1'b1;
        cyc(1);
        {mwr, smwr} = 2'b00;
        cyc(2);
        chk(10, mdat);
        chk(11, smdat);
        // Wake ignored while SPI is selected
        mst.wake(SC + 2, SC + 2);
        cyc(6);
        chk(7, 8'h00);
        twr(NOSEL, 1'b0, 1'b0, 1'b0, 1'b0);
        mst.wake(SC / 2, SC + 2);
        cyc(6);
        chk(7, 8'h00);
        chk(16, 8'h00);
        mst.wake(SC + 2, SC + 2);
        cyc(6);
        chk(7, 8'h01);
        chk(16, 8'h01);
        chk(5, 8'h00);
        cyc(4);
        chk(7, 8'h01);
        // Firmware service: DAC off first, then transceiver
        sdac = 1'b0;
        swr = 1'b1;
        cyc(1);
        sxcvr = 1'b1;
        cyc(1);
        swr = 1'b0;
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        cyc(3);
        chk(7, 8'h00);
        chk(6, 8'h01);
        {sdac, sxcvr, swr} = 3'h5;
        cyc(1);
        swr = 1'b0;
        twr(NOSEL, 1'b1, 1'b0, 1'b0, 1'b0);
        mst.wake(SC + 2, SC + 2);
        cyc(6);
        chk(7, 8'h00);
        mst.wake(LC + 2, LC + 2);
        cyc(6);
        chk(7, 8'h01);
        ack = 1'b1;
        cyc(1);
        ack = 1'b0;
        // Select and enable in one write; settle time scaled down
        twr(hlsow_pkg::LINK_SPL, 1'b0, 1'b1, 1'b0, 1'b0);
        cyc(20);
        chk(6, 8'h01);
        chk(5, 8'h00);
        chk(12, 8'h00);
        txreq = 1'b1;
        txbit = 1'b0;
        mst.drive(1'b0);
        cyc(3);
        chk(12, 8'h01);
        chk(15, 8'h00);
        chk(14, 8'h00);
        txreq = 1'b0;
        twr(hlsow_pkg::LINK_I2C, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(6, 8'h00);
        chk(5, 8'h01);
        chk(14, 8'h01);
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        fails++;
        stop_test();
    end
endmodule
